/* core/pfw_pkg.sv */
// Constants, field layouts and types of the pack switch and wake control
`default_nettype none
package pfw_pkg;

  // ==========================================================
  // Register port geometry
  localparam int DW    = 8;              // Register data width
  localparam int AW    = 8;              // Register address width
  localparam int SEL_W = 4;              // Monitor select width

  // ==========================================================
  // Register offsets
  localparam logic [AW-1:0] ADDR_CTRL = 8'h00;  // Control bits
  localparam logic [AW-1:0] ADDR_AMUX = 8'h04;  // Monitor select
  localparam logic [AW-1:0] ADDR_STAT = 8'h08;  // Sticky events
  localparam logic [AW-1:0] ADDR_MASK = 8'h0C;  // Event mask
  localparam logic [AW-1:0] ADDR_LIVE = 8'h10;  // Live state

  // ==========================================================
  // Monitor selection codes: two temperature sources and the reset value
  localparam logic [SEL_W-1:0] SEL_TEMP_EXT = 4'h8;  // Thermistor
  localparam logic [SEL_W-1:0] SEL_TEMP_INT = 4'h9;  // Die sensor
  localparam logic [SEL_W-1:0] SEL_RST      = 4'h0;  // After reset

  // ==========================================================
  // Field layouts
  typedef struct packed {
    logic [1:0] rsvd;           // Reads zero
    logic       sleep;          // Write 1 enters sleep
    logic       wake_pol;       // Wake polarity select
    logic       therm_cont;     // Bias switch held closed
    logic       load_sense_en;  // Load sense resistor on
    logic       chg_en;         // Charge switch command
    logic       dsg_en;         // Discharge switch command
  } pfw_ctrl_s;

  typedef struct packed {
    logic [1:0] rsvd;           // Reads zero
    logic       otemp;          // Over-temperature began
    logic       wake;           // Qualified wake edge
    logic       load_rel;       // Load released
    logic       charge_overcurrent_flag;            // Charge overcurrent flag
    logic       discharge_overcurrent_flag;            // Discharge overcurrent flag
    logic       short_ckt;      // Short-circuit flag
  } pfw_evt_s;

  typedef struct packed {
    logic       rsvd;           // Reads zero
    logic       asleep;         // Part is in sleep
    logic       bias;           // Thermistor bias closed
    logic       otemp;          // Over-temperature now
    logic       ld_fault;       // Load fault flag
    logic       chg_drv;        // Charge switch drive
    logic       dsg_drv;        // Discharge switch drive
    logic       wake_stat;      // Qualified wake level
  } pfw_live_s;

  // Analog comparator outputs, active high
  typedef struct packed {
    logic therm_low;            // Sense below bias/13
    logic load_rel;             // Load sense pin below limit
    logic charge_overcurrent_flag;                  // Charge overcurrent
    logic discharge_overcurrent_flag;                  // Discharge overcurrent
    logic short_ckt;            // Short circuit
  } pfw_det_s;

  localparam int DET_W = $bits(pfw_det_s);

  // ==========================================================
  // Reset values
  localparam pfw_ctrl_s      CTRL_RST = '0;
  localparam pfw_evt_s       EVT_RST  = '0;
  localparam logic [DW-1:0]  MASK_RST = 8'h00;
  localparam logic [DW-1:0]  DATA_0   = 8'h00;

  // Power state
  typedef enum logic {
    PWR_RUN   = 1'b0,
    PWR_SLEEP = 1'b1
  } pfw_pwr_e;

  // True when the selection measures a temperature
  function automatic logic pfw_is_temp(input logic [SEL_W-1:0] sel);
    return (sel == SEL_TEMP_EXT) || (sel == SEL_TEMP_INT);
  endfunction

endpackage
`default_nettype wire

/* core/pfw_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module pfw_sync #(
  parameter int W = 1                   // Number of levels
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  // ==========================================================
  // Stage flops; the first is read only by the second
  logic [W-1:0] meta_ff;                // First stage

  // Capture then settle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_ff  <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule // pfw_sync
`default_nettype wire

/* core/pfw_wake.sv */
// Wake input polarity qualification and edge detection
`timescale 1ns/1ps
`default_nettype none
module pfw_wake
  import pfw_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Synchronised pin level and polarity
  input  wire logic wake_lvl,
  input  wire logic wake_polarity_sel,
  // Results
  output logic      wake_stat,          // Qualified level
  output logic      wake_edge           // One-cycle pulse
);

  // ==========================================================
  // Previous level for edge finding
  logic prev_ff;                        // Level one cycle ago
  logic nxt_edge;                       // Edge of chosen sense

  // Rising edge when polarity 1, falling edge when 0
  assign nxt_edge = wake_polarity_sel ? (wake_lvl & ~prev_ff)
                                      : (~wake_lvl & prev_ff);

  // Level mirror and edge pulse
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prev_ff   <= 1'b0;
      wake_stat <= 1'b0;
      wake_edge <= 1'b0;
    end
    else
    begin
      prev_ff   <= wake_lvl;
      wake_stat <= wake_polarity_sel ? wake_lvl : ~wake_lvl;
      wake_edge <= nxt_edge;
    end
  end

  // ==========================================================
  // Checks
  chk_wake_level: assert property (
    @(posedge clk) disable iff (srst)
    !$past(srst) |-> wake_stat == ($past(wake_polarity_sel)
                                   ? $past(wake_lvl) : !$past(wake_lvl)))
    else $error("wake status does not follow the qualified level");

endmodule // pfw_wake
`default_nettype wire

/* core/pfw_ctrl.sv */
// Switch drive, fault, load release, bias and wake control with registers
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Switches turn on only by command bit
// - Short or overcurrent forces discharge drive off
// - Overcurrent forces charge drive off
// - Cleared discharge command turns drive off
// - Cleared charge command turns drive off
// - Load sense resistor on while bit set
// - Load release clears the load fault flag
// - Bias closed during temperature measurement
// - Continuous bias bit holds bias closed
// - Any short or overcurrent flag closes the bias
// - Sense below bias/13 flags over-temperature
// - Monitor output follows written selection
// - Only a wake edge leaves sleep
// - Polarity one: rising edge, high level
// - Polarity zero: falling edge, low level
// - Wake status bit mirrors present qualified level
module pfw_ctrl
  import pfw_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Register port
  input  wire logic [AW-1:0]    reg_addr,
  input  wire logic [DW-1:0]    reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [DW-1:0]    reg_rdata,
  // Analog comparators and wake pin, asynchronous
  input  wire pfw_det_s         det_async,
  input  wire logic             wake_input,
  // Power switch gates
  output logic                  discharge_switch_drive,
  output logic                  charge_switch_drive,
  // Load sense, thermistor and monitor
  output logic                  load_sense_pin_en,
  output logic                  thermistor_bias_out,
  output logic                  over_temp_ind,
  output logic      [SEL_W-1:0] analog_monitor_sel,
  // Power state and interrupt
  output logic                  sleep_mode,
  output logic                  irq
);

  // ==========================================================
  // Synchronised inputs
  pfw_det_s det;                        // Comparator levels
  logic     wake_lvl;                   // Wake pin level
  logic     wake_stat;                  // Qualified wake level
  logic     wake_edge;                  // Qualified wake edge

  // Comparators and wake pin pass two flops together
  pfw_sync #(
    .W        (DET_W + 1)
  ) u_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in ({det_async, wake_input}),
    .sync_out ({det, wake_lvl})
  );

  // ==========================================================
  // Register state
  pfw_ctrl_s        ctrl_ff;            // Control bits
  pfw_ctrl_s        nxt_ctrl;           // Next control bits
  logic [SEL_W-1:0] amux_ff;            // Monitor select
  pfw_evt_s         evt_ff;             // Sticky events
  pfw_evt_s         nxt_evt;            // Next sticky events
  logic [DW-1:0]    mask_ff;            // Event mask
  logic             ld_fault_ff;        // Load fault flag
  pfw_pwr_e         pwr_ff;             // Power state
  pfw_pwr_e         nxt_pwr;            // Next power state

  // Wake qualification by the stored polarity
  pfw_wake u_wake (
    .clk               (clk),
    .srst              (srst),
    .wake_lvl          (wake_lvl),
    .wake_polarity_sel (ctrl_ff.wake_pol),
    .wake_stat         (wake_stat),
    .wake_edge         (wake_edge)
  );

  // ==========================================================
  // Address decode
  logic wr_ctrl;                        // Control write
  logic wr_amux;                        // Select write
  logic wr_stat;                        // Event clear write
  logic wr_mask;                        // Mask write

  assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
  assign wr_amux = reg_wr && (reg_addr == ADDR_AMUX);
  assign wr_stat = reg_wr && (reg_addr == ADDR_STAT);
  assign wr_mask = reg_wr && (reg_addr == ADDR_MASK);

  // Write data seen through the control layout
  pfw_ctrl_s wr_ctrl_val;               // Control write fields
  assign wr_ctrl_val = pfw_ctrl_s'(reg_wdata);

  // ==========================================================
  // Fault decode
  logic     flag_any;                   // A fault flag is held
  logic     fault_dsg;                  // Discharge must be off
  logic     fault_chg;                  // Charge must be off
  logic     fault_det;                  // A fault is seen now
  logic     ld_clear;                   // Load released
  pfw_evt_s clr_evt;                    // Write-one-to-clear

  assign flag_any  = evt_ff.short_ckt | evt_ff.discharge_overcurrent_flag | evt_ff.charge_overcurrent_flag;
  assign fault_det = det.short_ckt | det.discharge_overcurrent_flag | det.charge_overcurrent_flag;
  // Short or either overcurrent opens discharge
  assign fault_dsg = fault_det | flag_any;
  // Either overcurrent opens charge
  assign fault_chg = det.discharge_overcurrent_flag | det.charge_overcurrent_flag
                   | evt_ff.discharge_overcurrent_flag | evt_ff.charge_overcurrent_flag;
  // Release seen only through the enabled sense resistor
  assign ld_clear  = ld_fault_ff & ctrl_ff.load_sense_en
                   & det.load_rel;
  assign clr_evt   = wr_stat ? pfw_evt_s'(reg_wdata) : EVT_RST;

  // ==========================================================
  // Next control bits; a fault clears the switch command
  always_comb
  begin
    nxt_ctrl = wr_ctrl ? wr_ctrl_val : ctrl_ff;
    nxt_ctrl.rsvd  = 2'b00;
    nxt_ctrl.sleep = 1'b0;
    // Fault wins over a write so a switch never restarts alone
    if (fault_dsg)
    begin
      nxt_ctrl.dsg_en = 1'b0;
    end
    if (fault_chg)
    begin
      nxt_ctrl.chg_en = 1'b0;
    end
  end

  // Next sticky events; a new event wins over its clear
  always_comb
  begin
    nxt_evt = evt_ff & ~clr_evt;
    nxt_evt.rsvd = 2'b00;
    // Fault flags stay until cleared by software
    nxt_evt.short_ckt = nxt_evt.short_ckt | det.short_ckt;
    nxt_evt.discharge_overcurrent_flag       = nxt_evt.discharge_overcurrent_flag | det.discharge_overcurrent_flag;
    nxt_evt.charge_overcurrent_flag       = nxt_evt.charge_overcurrent_flag | det.charge_overcurrent_flag;
    nxt_evt.load_rel  = nxt_evt.load_rel | ld_clear;
    nxt_evt.wake      = nxt_evt.wake | wake_edge;
    nxt_evt.otemp     = nxt_evt.otemp
                      | (det.therm_low & ~over_temp_ind);
  end

  // ==========================================================
  // Power state: write enters sleep, qualified edge leaves
  always_comb
  begin
    nxt_pwr = pwr_ff;
    unique case (pwr_ff)
      PWR_RUN:
      begin
        if (wr_ctrl && wr_ctrl_val.sleep)
        begin
          nxt_pwr = PWR_SLEEP;
        end
      end
      PWR_SLEEP:
      begin
        // A steady level never wakes
        if (wake_edge)
        begin
          nxt_pwr = PWR_RUN;
        end
      end
    endcase
  end

  // ==========================================================
  // Read data selection
  pfw_ctrl_s     rd_ctrl;               // Control with sleep state
  pfw_live_s     live;                  // Live state
  logic [DW-1:0] nxt_rdata;             // Selected read data

  always_comb
  begin
    rd_ctrl = ctrl_ff;
    rd_ctrl.sleep = (pwr_ff == PWR_SLEEP);
  end

  assign live = '{rsvd: 1'b0, asleep: sleep_mode,
                  bias: thermistor_bias_out, otemp: over_temp_ind,
                  ld_fault: ld_fault_ff, chg_drv: charge_switch_drive,
                  dsg_drv: discharge_switch_drive,
                  wake_stat: wake_stat};

  // Unmapped addresses and idle cycles read zero
  assign nxt_rdata = !reg_rd                ? DATA_0
                   : reg_addr == ADDR_CTRL  ? DW'(rd_ctrl)
                   : reg_addr == ADDR_AMUX  ? DW'(amux_ff)
                   : reg_addr == ADDR_STAT  ? DW'(evt_ff)
                   : reg_addr == ADDR_MASK  ? mask_ff
                   : reg_addr == ADDR_LIVE  ? DW'(live)
                   : DATA_0;

  // ==========================================================
  // Register file
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_ff <= CTRL_RST;
      amux_ff <= SEL_RST;
      evt_ff  <= EVT_RST;
      mask_ff <= MASK_RST;
      pwr_ff  <= PWR_RUN;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      evt_ff  <= nxt_evt;
      pwr_ff  <= nxt_pwr;
      if (wr_amux)
      begin
        amux_ff <= reg_wdata[SEL_W-1:0];
      end
      if (wr_mask)
      begin
        mask_ff <= reg_wdata;
      end
    end
  end

  // Load fault: set by a fault, cleared by release
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ld_fault_ff <= 1'b0;
    end
    else
    begin
      ld_fault_ff <= fault_det | (ld_fault_ff & ~ld_clear);
    end
  end

  // ==========================================================
  // Output flops
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      discharge_switch_drive <= 1'b0;
      charge_switch_drive    <= 1'b0;
      load_sense_pin_en      <= 1'b0;
      thermistor_bias_out    <= 1'b0;
      over_temp_ind          <= 1'b0;
      analog_monitor_sel     <= SEL_RST;
      sleep_mode             <= 1'b0;
      irq                    <= 1'b0;
      reg_rdata              <= DATA_0;
    end
    else
    begin
      // Drive only on command; discharge never during a fault, charge never during overcurrent
      discharge_switch_drive <= ctrl_ff.dsg_en & ~fault_dsg;
      charge_switch_drive    <= ctrl_ff.chg_en & ~fault_chg;
      load_sense_pin_en      <= ctrl_ff.load_sense_en;
      // Measurement, continuous bit or fault flag close bias
      thermistor_bias_out    <= pfw_is_temp(amux_ff)
                              | ctrl_ff.therm_cont
                              | flag_any;
      over_temp_ind          <= det.therm_low;
      analog_monitor_sel     <= amux_ff;
      sleep_mode             <= (nxt_pwr == PWR_SLEEP);
      irq                    <= |(DW'(evt_ff) & mask_ff);
      reg_rdata              <= nxt_rdata;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_dsg_on_cmd: assert property (
    $rose(discharge_switch_drive) |-> $past(ctrl_ff.dsg_en))
    else $error("discharge drive rose without command");
  chk_dsg_fault_off: assert property (
    (det.short_ckt || det.discharge_overcurrent_flag || det.charge_overcurrent_flag) |=> !discharge_switch_drive
      ##1 !ctrl_ff.dsg_en)
    else $error("discharge drive stayed on in a fault");
  chk_chg_fault_off: assert property (
    (det.discharge_overcurrent_flag || det.charge_overcurrent_flag) |=> !charge_switch_drive)
    else $error("charge drive stayed on in overcurrent");
  chk_dsg_cmd_off: assert property (
    (wr_ctrl && !wr_ctrl_val.dsg_en) |-> ##2 !discharge_switch_drive)
    else $error("discharge drive on after command cleared");
  chk_chg_cmd_off: assert property (
    (wr_ctrl && !wr_ctrl_val.chg_en) |-> ##2 !charge_switch_drive)
    else $error("charge drive on after command cleared");
  chk_load_sense: assert property (
    (wr_ctrl && wr_ctrl_val.load_sense_en) |-> ##2 load_sense_pin_en)
    else $error("load sense resistor not connected");
  chk_ldfault_clear: assert property (
    (ld_clear && !fault_det) |=> !ld_fault_ff)
    else $error("load fault flag not cleared on release");
  chk_bias_close: assert property (
    (pfw_is_temp(amux_ff) || ctrl_ff.therm_cont || flag_any)
      |=> thermistor_bias_out)
    else $error("thermistor bias not closed");
  chk_bias_open: assert property (
    !(pfw_is_temp(amux_ff) || ctrl_ff.therm_cont || flag_any)
      |=> !thermistor_bias_out)
    else $error("thermistor bias closed without cause");
  chk_over_temp: assert property (
    det.therm_low |=> over_temp_ind)
    else $error("over-temperature not indicated");
  chk_monitor_sel: assert property (
    wr_amux |-> ##2 analog_monitor_sel == $past(reg_wdata[SEL_W-1:0], 2))
    else $error("monitor select does not follow write");
  chk_sleep_hold: assert property (
    (pwr_ff == PWR_SLEEP && !wake_edge) |=> pwr_ff == PWR_SLEEP)
    else $error("left sleep without a wake edge");
  chk_wake_leave: assert property (
    (pwr_ff == PWR_SLEEP && wake_edge) |=> pwr_ff == PWR_RUN && !sleep_mode)
    else $error("wake edge did not leave sleep");
  chk_flag_hold: assert property (
    (evt_ff.short_ckt && !clr_evt.short_ckt) |=> evt_ff.short_ckt)
    else $error("short-circuit flag lost without clear");

  cov_short_trip: cover property (
    discharge_switch_drive ##1 det.short_ckt ##1 !discharge_switch_drive);
  cov_load_release: cover property (ld_fault_ff ##[1:50] ld_clear);
  cov_sleep_wake: cover property (
    pwr_ff == PWR_SLEEP ##[1:200] pwr_ff == PWR_RUN);
  cov_temp_measure: cover property ($rose(thermistor_bias_out));

endmodule // pfw_ctrl
`default_nettype wire

/* verif/pfw_pack_model.sv */
// Pack-side model of the comparators and the wake pin
`timescale 1ns/1ps
`default_nettype none
module pfw_pack_model
  import pfw_pkg::*;
(
  // Requested pack conditions
  input  wire pfw_det_s fault_lvl,
  input  wire logic     wake_req,
  // Pins toward the block
  output wire pfw_det_s det_async,
  output var  logic     wake_input
);
  // ==========================================================
  // Link clock, 160 ns, phase unrelated to the block clock
  logic link_clk;  // Pin pacing clock

  // Free running pin pacing clock with an odd start offset
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #80 link_clk = ~link_clk;
  end

  // Comparators settle a few ns after the analog change
  assign #3 det_async = fault_lvl;

  // Wake pin moves only on link clock edges
  always @(posedge link_clk)
    wake_input <= wake_req;
endmodule // pfw_pack_model
`default_nettype wire

/* verif/test_pfw_ctrl.sv */
// Self-checking bench of the pack switch and wake control
`timescale 1ns/1ps
`default_nettype none
module test_pfw_ctrl
  import pfw_pkg::*;
;
  // ==========================================================
  // Signals
  logic             clk;         // Block clock
  logic             srst;        // Synchronous reset
  logic [AW-1:0]    reg_addr;    // Register address
  logic [DW-1:0]    reg_wdata;   // Write data
  logic             reg_wr;      // Write strobe
  logic             reg_rd;      // Read strobe
  logic [DW-1:0]    reg_rdata;   // Read data
  pfw_det_s         det_async;   // Comparator pins
  logic             wake_input;  // Wake pin
  pfw_det_s         fault_lvl;   // Requested conditions
  logic             wake_req;    // Requested wake level
  logic             dsg;         // Discharge drive
  logic             chg;         // Charge drive
  logic             ld_en;       // Load sense resistor
  logic             bias;        // Thermistor bias
  logic             otemp;       // Over-temperature
  logic [SEL_W-1:0] mon_sel;     // Monitor select
  logic             sleep_mode;  // Asleep
  logic             irq;         // Interrupt
  logic [DW-1:0]    rd_val;      // Last read value
  int               n_mismatch;  // Mismatches seen
  int               n_compared;  // Comparisons made
  // Output byte: b0 dsg b1 chg b2 load b3 bias b4 otemp b5 sleep b6 irq
  wire  [DW-1:0]    pins = {1'b0, irq, sleep_mode, otemp, bias, ld_en,
                            chg, dsg};
  localparam logic [AW-1:0] RST_A [6] = '{ADDR_CTRL, ADDR_AMUX, ADDR_STAT,
                                          ADDR_MASK, ADDR_LIVE, 8'h14};
  localparam logic [DW-1:0] RST_V [6] = '{8'h00, 8'h00, 8'h00, 8'h00,
                                          8'h01, 8'h00};
  localparam logic [SEL_W-1:0] SEL_T [4] = '{4'h3, 4'h8, 4'h9, 4'hF};
  localparam logic [DW-1:0] BIAS_T [4] = '{8'h00, 8'h08, 8'h08, 8'h00};

  // ==========================================================
  // Instances
  pfw_ctrl i_pfw_ctrl (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .det_async(det_async), .wake_input(wake_input),
    .discharge_switch_drive(dsg), .charge_switch_drive(chg),
    .load_sense_pin_en(ld_en), .thermistor_bias_out(bias),
    .over_temp_ind(otemp), .analog_monitor_sel(mon_sel),
    .sleep_mode(sleep_mode), .irq(irq));

  pfw_pack_model i_pfw_pack_model (
    .fault_lvl(fault_lvl), .wake_req(wake_req),
    .det_async(det_async), .wake_input(wake_input));

  // ==========================================================
  // Tasks
  // Compare and count
  task automatic check(input string what, input logic [DW-1:0] seen,
                       input logic [DW-1:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read, data taken in the following cycle
  task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] e,
                        input string what);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
    check(what, rd_val, e);
  endtask

  // Let synchronisers and output flops land
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Compare the output byte after settling; covers a full link period
  task automatic pin_chk(input string what, input logic [DW-1:0] e);
    settle(16);
    check(what, pins, e);
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // Clock, 20 ns period
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    srst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fault_lvl = '0;
    wake_req = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    // Reset values, unmapped place reads zero
    for (int i = 0; i < 6; i++)
      rd_chk(RST_A[i], RST_V[i], "reset_reg");
    pin_chk("reset_pins", 8'h00);
    // Commanded on, then each command cleared alone
    wr(ADDR_CTRL, 8'h03);
    pin_chk("both_on", 8'h03);
    wr(ADDR_CTRL, 8'h02);
    pin_chk("dsg_cleared", 8'h02);
    wr(ADDR_CTRL, 8'h01);
    pin_chk("chg_cleared", 8'h01);
    // Short, discharge and charge overcurrent in turn
    wr(ADDR_MASK, 8'h07);
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_CTRL, 8'h03);
      pin_chk("cmd_on", 8'h03);
      fault_lvl <= pfw_det_s'(5'(1 << i));
      settle(8);
      fault_lvl <= '0;
      pin_chk("fault_pins", (i == 0) ? 8'h4A : 8'h48);
      rd_chk(ADDR_STAT, 8'(1 << i), "stat_fault");
      wr(ADDR_STAT, 8'hFF);
      // A short leaves the charge switch on
      pin_chk("no_return", (i == 0) ? 8'h02 : 8'h00);
    end
    // Load release recovery
    wr(ADDR_CTRL, 8'h04);
    pin_chk("load_res", 8'h04);
    rd_chk(ADDR_LIVE, 8'h09, "ld_fault_set");
    fault_lvl <= 5'h08;
    settle(8);
    rd_chk(ADDR_LIVE, 8'h01, "ld_fault_clr");
    fault_lvl <= '0;
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_STAT, 8'hFF);
    // Monitor selection and bias during temperature selection
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_AMUX, {4'h0, SEL_T[i]});
      pin_chk("bias_sel", BIAS_T[i]);
      check("mon_sel", {4'h0, mon_sel}, {4'h0, SEL_T[i]});
      rd_chk(ADDR_AMUX, {4'h0, SEL_T[i]}, "amux_rb");
    end
    wr(ADDR_CTRL, 8'h08);
    pin_chk("bias_cont", 8'h08);
    wr(ADDR_CTRL, 8'h00);
    // Over-temperature, its event masked off
    fault_lvl <= 5'h10;
    pin_chk("otemp_on", 8'h10);
    fault_lvl <= '0;
    pin_chk("otemp_off", 8'h00);
    wr(ADDR_STAT, 8'hFF);
    // Wake level for both polarities
    wake_req <= 1'b1;
    settle(12);
    rd_chk(ADDR_LIVE, 8'h00, "wake_lvl_p0");
    wr(ADDR_CTRL, 8'h10);
    settle(4);
    rd_chk(ADDR_LIVE, 8'h01, "wake_lvl_p1");
    wr(ADDR_STAT, 8'hFF);
    // Asleep with polarity one: steady and falling levels keep sleep
    wr(ADDR_CTRL, 8'h30);
    pin_chk("asleep", 8'h20);
    settle(40);
    check("steady", pins, 8'h20);
    wake_req <= 1'b0;
    pin_chk("fall_p1", 8'h20);
    wake_req <= 1'b1;
    pin_chk("rise_p1", 8'h00);
    rd_chk(ADDR_STAT, 8'h10, "wake_evt");
    // Polarity zero: falling edge wakes, event raises the interrupt
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_STAT, 8'hFF);
    wr(ADDR_MASK, 8'h10);
    wr(ADDR_CTRL, 8'h20);
    pin_chk("asleep_p0", 8'h20);
    wake_req <= 1'b0;
    pin_chk("fall_p0", 8'h40);
    wr(ADDR_STAT, 8'hFF);
    pin_chk("irq_clr", 8'h00);
    complete_run();
  end
endmodule // test_pfw_ctrl
`default_nettype wire
